/* File: hw/ddr3_wl_pkg.sv */
// Shared constants for the write leveling controller and memory model
package ddr3_wl_pkg;
	// Link widths
	localparam int LANES = 2;
	localparam int DQ_W  = 16;
	localparam int MR_W  = 16;
	localparam int BA_W  = 3;
	localparam int PRIME_HI = 8;
	localparam int BYTE_W   = 8;
	// Command bus encodings
	localparam logic [1:0] CMD_DES = 2'h0;
	localparam logic [1:0] CMD_NOP = 2'h1;
	localparam logic [1:0] CMD_MRS = 2'h2;
	// Mode register 1 layout
	localparam logic [BA_W-1:0] BA_MR1 = 3'h1;
	localparam int MR1_WL   = 7;
	localparam int MR1_QOFF = 12;
	localparam logic [MR_W-1:0] MR1_BASE = 16'h0044;
	// Clock division: one link clock period is 16 system cycles, one wrap of the PH_W-bit phase
	localparam int PH_W = 4;
	localparam logic [PH_W-1:0] PH_LAST = 4'hF;
	localparam logic [PH_W-1:0] PH_FALL = 4'h7;
	// Strobe sweep
	localparam int DLY_W = 4;
	localparam logic [DLY_W-1:0] DLY_MAX = 4'hF;
	localparam logic [4:0] DQSH_CYC = 5'h08;
	// Waits, counted in link clock periods
	localparam int WAIT_W = 8;
	localparam logic [WAIT_W-1:0] T_MOD_CK   = 8'h0C;
	localparam logic [WAIT_W-1:0] WL_CK      = 8'h05;
	localparam logic [WAIT_W-1:0] ODTL_CK    = WL_CK - 8'h02;
	localparam logic [WAIT_W-1:0] T_WLMRD_CK = 8'h28;
	localparam logic [WAIT_W-1:0] T_CAPT_CK  = 8'h02;
	// APB register map
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_DELAY  = 8'h08;
	localparam int CTRL_START = 0;
	localparam int CTRL_QUIET = 1;
	localparam int CTRL_X16   = 2;
	localparam int ST_BUSY  = 0;
	localparam int ST_DONE  = 1;
	localparam int ST_FAIL  = 2;
	localparam int ST_LOCK  = 4;
	localparam int DLY1_POS = 8;
endpackage : ddr3_wl_pkg

/* File: hw/ddr3_wl_if.sv */
// Link between the leveling controller and the memory device
`timescale 1ns/1ps
interface ddr3_wl_if;
	import ddr3_wl_pkg::*;
	logic             ck;
	logic [1:0]       cmd;
	logic [BA_W-1:0]  ba;
	logic [MR_W-1:0]  addr;
	logic             odt;
	logic [LANES-1:0] dqsOut;
	logic [LANES-1:0] dqsOe;
	logic [DQ_W-1:0]  dqOutDev;
	logic [DQ_W-1:0]  dqOeDev;
	logic [DQ_W-1:0]  dqOutCtl;
	logic [DQ_W-1:0]  dqOeCtl;
	logic [LANES-1:0] dqs;
	logic [DQ_W-1:0]  dq;

	// Wire levels; an undriven line reads low
	assign dqs = dqsOut & dqsOe;
	assign dq  = (dqOutDev & dqOeDev) | (dqOutCtl & dqOeCtl);

	modport mem (input ck, cmd, ba, addr, odt, dqs,
		output dqOutDev, dqOeDev);
	modport ctl (output ck, cmd, ba, addr, odt, dqsOut, dqsOe,
		dqOutCtl, dqOeCtl, input dq);
endinterface : ddr3_wl_if

/* File: hw/ddr3_wl_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ddr3_wl_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] stage;

	// First stage feeds only the second
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage <= '0;
			dout  <= '0;
		end else begin
			stage <= din;
			dout  <= stage;
		end
	end
endmodule : ddr3_wl_sync

/* File: hw/ddr3_wl_device.sv */
// Memory-side write leveling feedback
`timescale 1ns/1ps
module ddr3_wl_device
	import ddr3_wl_pkg::*;
(
	input  wire logic  clock,
	input  wire logic  rst_n,
	ddr3_wl_if.mem     link,
	input  wire logic  x16Mode,
	output logic       levelingOn,
	output logic       outputsOn,
	output logic       dqsTermOn,
	output logic       dqTermOn
);
	localparam int SW = 4 + LANES + BA_W + MR_W;

	logic [SW-1:0]     syncIn;
	logic [SW-1:0]     syncOut;
	logic              odtS;
	logic              ckS;
	logic [LANES-1:0]  dqsS;
	logic [1:0]        cmdS;
	logic [BA_W-1:0]   baS;
	logic [MR_W-1:0]   addrS;
	logic              ckPrev;
	logic [LANES-1:0]  dqsPrev;
	logic [MR_W-1:0]   mr1;
	logic              wlEn;
	logic              active;
	logic [DQ_W-1:0]   dqOut;
	logic [DQ_W-1:0]   dqOe;

	////////////////////////////////////////////////////////////////////////
	// Pin inputs pass two flops
	assign syncIn = {link.odt, link.ck, link.dqs, link.cmd, link.ba,
		link.addr};
	assign {odtS, ckS, dqsS, cmdS, baS, addrS} = syncOut;

	ddr3_wl_sync #(.W(SW)) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.din   (syncIn),
		.dout  (syncOut)
	);

	// Edge history of clock and strobes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ckPrev  <= 1'b0;
			dqsPrev <= '0;
		end else begin
			ckPrev  <= ckS;
			dqsPrev <= dqsS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register 1 is taken at a link clock rising edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mr1 <= '0;
		end else if (ckS && !ckPrev && cmdS == CMD_MRS && baS == BA_MR1) begin
			mr1 <= addrS;
		end
	end

	assign wlEn   = mr1[MR1_WL];
	assign active = wlEn && !mr1[MR1_QOFF];

	////////////////////////////////////////////////////////////////////////
	// Feedback per lane; lane 1 reports on the upper byte
	genvar l;
	generate
		for (l = 0; l < LANES; l++) begin : g_lane
			logic laneOn;
			assign laneOn = active && (l == 0 || x16Mode);
			// Strobe rise captures link clock level
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					dqOut[l*PRIME_HI] <= 1'b0;
				end else if (!laneOn) begin
					dqOut[l*PRIME_HI] <= 1'b0;
				end else if (dqsS[l] && !dqsPrev[l]) begin
					dqOut[l*PRIME_HI] <= ckS;
				end
			end
			// Non-prime lines of the byte drive low
			assign dqOut[l*BYTE_W+BYTE_W-1:l*BYTE_W+1] = '0;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					dqOe[l*BYTE_W+BYTE_W-1:l*BYTE_W] <= '0;
				end else begin
					// Whole byte driven while on
					dqOe[l*BYTE_W+BYTE_W-1:l*BYTE_W] <= {BYTE_W{laneOn}};
				end
			end
		end
	endgenerate

	assign link.dqOutDev = dqOut;
	assign link.dqOeDev  = dqOe;

	////////////////////////////////////////////////////////////////////////
	// Status and termination; data lines ignore ODT while leveling
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			levelingOn <= 1'b0;
			outputsOn  <= 1'b0;
			dqsTermOn  <= 1'b0;
			dqTermOn   <= 1'b0;
		end else begin
			levelingOn <= wlEn;
			outputsOn  <= !mr1[MR1_QOFF];
			dqsTermOn  <= odtS;
			dqTermOn   <= odtS && !wlEn;
		end
	end
endmodule : ddr3_wl_device

/* File: hw/ddr3_wl_ctrl.sv */
// Controller end: sweeps strobe delay per byte lane, APB register access
`timescale 1ns/1ps
// Notes on behaviour
// - strobe rise samples clock, fed back on data
// - narrow parts: DQ0 prime, others low
// - wide parts: DQ0 and DQ8 prime per byte
// - MR1 bit 7 enables leveling; off normally
// - MR1 bit 12 set turns outputs off
// - ODT switches strobe termination only
// - outputs off allows any termination value
// - outputs on allows 40, 60, 120 ohm
// - only NOP or deselect while leveling
// - enter only after init and DLL lock
// - data lines driven on entry; controller releases
// - level one rank; others outputs off
// - raise ODT after tMOD, before strobe low
// - strobe low after tWLDQSEN, toggle after tWLMRD
// - pulses meet minimum high and low widths
// - prime line follows capture within tWLO
// - non-prime lines low after first tWLO
// - step delay until 0-to-1 seen, then lock
// - release strobe after tWLO plus capture margin
// - drop ODT so turn-off follows strobe release
// - exit by mode write, then wait tMOD; quiet runs end after entry tMOD with no exit write
module ddr3_wl_ctrl
	import ddr3_wl_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	ddr3_wl_if.ctl                 link,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              initDone,
	output logic                   busy
);
	typedef enum {
		S_IDLE, S_ENTER, S_MOD, S_ODT, S_DQSEN, S_PULSE,
		S_CAPT, S_DECIDE, S_ODTOFF, S_EXIT, S_EXMOD
	} state_t;

	state_t                  state;
	logic [PH_W-1:0]         phase;
	logic                    ckTick;
	logic [WAIT_W-1:0]       waitCnt;
	logic                    waitDone;
	logic                    pulseHalf;
	logic [4:0]              pcnt;
	logic                    quiet;
	logic                    wide;
	logic                    done;
	logic                    fail;
	logic [LANES-1:0]        laneUsed;
	logic [LANES-1:0]        locked;
	logic [LANES-1:0]        laneFail;
	logic [LANES-1:0]        fbS;
	logic [LANES*DLY_W-1:0]  delay;
	logic                    evalNow;
	logic                    apbDone;
	logic                    startReq;
	logic                    mapped;
	logic [31:0]             rdMux;

	////////////////////////////////////////////////////////////////////////
	// Link clock divider; rises when phase wraps to zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase   <= '0;
			link.ck <= 1'b0;
		end else begin
			phase <= phase + 4'h1;
			if (phase == PH_LAST) begin
				link.ck <= 1'b1;
			end else if (phase == PH_FALL) begin
				link.ck <= 1'b0;
			end
		end
	end

	assign ckTick   = phase == PH_LAST;
	assign waitDone = waitCnt == '0;
	assign pcnt     = {pulseHalf, phase};
	assign evalNow  = state == S_CAPT && ckTick && waitDone;

	// Feedback lines from the device pass two flops
	ddr3_wl_sync #(.W(LANES)) u_fbSync (
		.clock (clock),
		.rst_n (rst_n),
		.din   ({link.dq[PRIME_HI], link.dq[0]}),
		.dout  (fbS)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer; command, address, ODT and strobe enable move only at period ends
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state      <= S_IDLE;
			waitCnt    <= '0;
			pulseHalf  <= 1'b0;
			link.cmd   <= CMD_NOP;
			link.ba    <= '0;
			link.addr  <= '0;
			link.odt   <= 1'b0;
			link.dqsOe <= '0;
			done       <= 1'b0;
			fail       <= 1'b0;
		end else begin
			if (startReq) begin
				done <= 1'b0;
			end
			if (ckTick) begin
				link.cmd <= CMD_NOP;
				if (!waitDone) begin
					waitCnt <= waitCnt - 8'h01;
				end
				unique case (state)
				S_IDLE: ; // Start is taken below, off the tick
				S_ENTER: begin
					link.cmd  <= CMD_MRS;
					link.ba   <= BA_MR1;
					link.addr <= MR1_BASE;
					link.addr[MR1_WL]   <= 1'b1;
					link.addr[MR1_QOFF] <= quiet;
					waitCnt <= T_MOD_CK;
					fail    <= 1'b0;
					state   <= S_MOD;
				end
				S_MOD: begin
					if (waitDone && quiet) begin
						done  <= 1'b1;
						state <= S_IDLE;
					end else if (waitDone) begin
						link.odt <= 1'b1;
						waitCnt  <= ODTL_CK + 8'h01;
						state    <= S_ODT;
					end
				end
				S_ODT: begin
					if (waitDone) begin
						link.dqsOe <= laneUsed;
						waitCnt    <= T_WLMRD_CK;
						state      <= S_DQSEN;
					end
				end
				S_DQSEN: begin
					if (waitDone) begin
						pulseHalf <= 1'b0;
						state     <= S_PULSE;
					end
				end
				S_PULSE: begin
					pulseHalf <= 1'b1;
					if (pulseHalf) begin
						waitCnt <= T_CAPT_CK - 8'h01;
						state   <= S_CAPT;
					end
				end
				S_CAPT: begin
					if (waitDone) begin
						state <= S_DECIDE;
					end
				end
				S_DECIDE: begin
					if ((locked | laneFail) == laneUsed) begin
						fail       <= |laneFail;
						link.dqsOe <= '0;
						link.odt   <= 1'b0;
						waitCnt    <= ODTL_CK;
						state      <= S_ODTOFF;
					end else begin
						pulseHalf <= 1'b0;
						state     <= S_PULSE;
					end
				end
				S_ODTOFF: begin
					if (waitDone) begin
						state <= S_EXIT;
					end
				end
				S_EXIT: begin
					link.cmd  <= CMD_MRS;
					link.ba   <= BA_MR1;
					link.addr <= MR1_BASE;
					waitCnt   <= T_MOD_CK;
					state     <= S_EXMOD;
				end
				S_EXMOD: begin
					if (waitDone) begin
						done  <= 1'b1;
						state <= S_IDLE;
					end
				end
				endcase
			end
			if (state == S_IDLE && startReq && initDone) begin
				state <= S_ENTER;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-lane sweep: delay steps until a 0 then 1 pair is seen
	genvar l;
	generate
		for (l = 0; l < LANES; l++) begin : g_lane
			logic [DLY_W-1:0] dly;
			logic             prev;
			logic [4:0]       rise;
			assign dly  = delay[l*DLY_W +: DLY_W];
			assign rise = {1'b0, dly};
			// Strobe shape: high for half a period at the chosen offset
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					link.dqsOut[l] <= 1'b0;
				end else begin
					// Width fixed, offset swept
					link.dqsOut[l] <= state == S_PULSE && laneUsed[l] &&
						!locked[l] && pcnt >= rise && pcnt < rise + DQSH_CYC;
				end
			end
			// Delay stepping and lock; a miss at the last setting fails
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					delay[l*DLY_W +: DLY_W] <= '0;
					prev        <= 1'b1;
					locked[l]   <= 1'b0;
					laneFail[l] <= 1'b0;
				end else if (state == S_ENTER) begin
					delay[l*DLY_W +: DLY_W] <= '0;
					prev        <= 1'b1;
					locked[l]   <= 1'b0;
					laneFail[l] <= 1'b0;
				end else if (evalNow && laneUsed[l] && !locked[l] &&
					!laneFail[l]) begin
					if (!prev && fbS[l]) begin
						locked[l] <= 1'b1;
					end else if (dly == DLY_MAX) begin
						// Last setting is tried before giving up
						laneFail[l] <= 1'b1;
					end else begin
						prev <= fbS[l];
						delay[l*DLY_W +: DLY_W] <= dly + 4'h1;
					end
				end
			end
		end
	endgenerate

	// Controller never drives the data lines; the device owns them
	assign link.dqOutCtl = '0;
	assign link.dqOeCtl  = '0;

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, read data registered with pready
	assign apbDone  = psel && penable && pready;
	assign startReq = apbDone && pwrite && paddr == REG_CTRL &&
		pwdata[CTRL_START];
	assign laneUsed = {wide, 1'b1};
	assign mapped   = paddr == REG_CTRL || paddr == REG_STATUS ||
		paddr == REG_DELAY;

	always_comb begin
		rdMux = '0;
		if (paddr == REG_CTRL) begin
			rdMux[CTRL_QUIET] = quiet;
			rdMux[CTRL_X16]   = wide;
		end else if (paddr == REG_STATUS) begin
			rdMux[ST_BUSY] = state != S_IDLE;
			rdMux[ST_DONE] = done;
			rdMux[ST_FAIL] = fail;
			rdMux[ST_LOCK +: LANES] = locked;
		end else if (paddr == REG_DELAY) begin
			rdMux[DLY_W-1:0] = delay[DLY_W-1:0];
			rdMux[DLY1_POS +: DLY_W] = delay[LANES*DLY_W-1:DLY_W];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			prdata  <= rdMux;
		end
	end

	// Mode bits only change while idle, so a sweep sees stable settings
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= 1'b0;
			wide  <= 1'b0;
			busy  <= 1'b0;
		end else begin
			busy <= state != S_IDLE;
			if (apbDone && pwrite && paddr == REG_CTRL && state == S_IDLE) begin
				quiet <= pwdata[CTRL_QUIET];
				wide  <= pwdata[CTRL_X16];
			end
		end
	end
endmodule : ddr3_wl_ctrl

/* File: testbench/ddr3_wl_checker.sv */
// Link assertions for the write leveling controller and memory ends
`timescale 1ns/1ps
module ddr3_wl_checker
	import ddr3_wl_pkg::*;
(
	input wire logic             clock,
	input wire logic             rst_n,
	input wire logic             ck,
	input wire logic             odt,
	input wire logic [LANES-1:0] dqs,
	input wire logic [LANES-1:0] dqsOe,
	input wire logic [DQ_W-1:0]  dqOutDev,
	input wire logic [DQ_W-1:0]  dqOeDev,
	input wire logic [DQ_W-1:0]  dq,
	input wire logic             levelingOn,
	input wire logic             outputsOn,
	input wire logic             dqsTermOn,
	input wire logic             dqTermOn,
	input wire logic             x16Mode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Feedback: clock held steady around the strobe rise avoids sync skew
	property p_prime_lo;
		$rose(dqs[0]) && levelingOn && outputsOn && $stable(ck) ##1
		$stable(ck) |-> ##3 dq[0] == $past(ck, 4);
	endproperty
	a_prime_lo: assert property (p_prime_lo)
		else $error("lane 0 feedback wrong");
	property p_prime_hi;
		$rose(dqs[1]) && x16Mode && levelingOn && outputsOn && $stable(ck)
		##1 $stable(ck) |-> ##3 dq[PRIME_HI] == $past(ck, 4);
	endproperty
	a_prime_hi: assert property (p_prime_hi)
		else $error("lane 1 feedback wrong");
	property p_other_lo;
		$past(levelingOn) && $past(outputsOn) && levelingOn |->
		dqOeDev[7:1] == 7'h7F && dqOutDev[7:1] == 7'h00;
	endproperty
	a_other_lo: assert property (p_other_lo)
		else $error("lower non-prime lines not low");
	property p_other_hi;
		x16Mode && $past(levelingOn) && $past(outputsOn) && levelingOn |->
		dqOeDev[15:8] == 8'hFF && dqOutDev[15:9] == 7'h00;
	endproperty
	a_other_hi: assert property (p_other_hi)
		else $error("upper byte not driven as required");

	////////////////////////////////////////////////////////////////////////
	// Output gating and release of the data lines
	property p_quiet;
		levelingOn && !outputsOn |-> dqOeDev == 16'h0000;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("data driven with outputs off");
	property p_release;
		!levelingOn |-> dqOeDev == 16'h0000;
	endproperty
	a_release: assert property (p_release)
		else $error("data driven outside leveling");
	property p_dq_term;
		$past(levelingOn) && levelingOn |-> !dqTermOn;
	endproperty
	a_dq_term: assert property (p_dq_term)
		else $error("data termination on while leveling");
	// Strobe termination trails the pin by the two sync flops and one more
	property p_dqs_term;
		dqsTermOn == $past(odt, 3);
	endproperty
	a_dqs_term: assert property (p_dqs_term)
		else $error("strobe termination not following ODT");

	////////////////////////////////////////////////////////////////////////
	// Strobe and termination ordering from the controller
	property p_odt_first;
		$rose(dqsOe[0]) |-> odt && $past(odt, 48);
	endproperty
	a_odt_first: assert property (p_odt_first)
		else $error("termination raised too late");
	property p_width;
		$rose(dqs[0]) |-> dqs[0] [*8] ##1 !dqs[0];
	endproperty
	a_width: assert property (p_width)
		else $error("strobe high width wrong");
	property p_odt_off;
		$fell(dqsOe[0]) |-> !odt && $past(odt);
	endproperty
	a_odt_off: assert property (p_odt_off)
		else $error("termination not dropped with strobe");
endmodule : ddr3_wl_checker

/* File: testbench/test_ddr3_write_leveling.sv */
// Self-checking bench: controller and memory joined through the link
`timescale 1ns/1ps
module test_ddr3_write_leveling;
	import ddr3_wl_pkg::*;
	logic              clock, rst_n, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd, tmp;
	logic              pready, pslverr, err, initDone, busy, x16Mode;
	logic              levelingOn, outputsOn, dqsTermOn, dqTermOn;
	logic              ckQ, quietSeen;
	logic [LANES-1:0]  dqsQ;
	int                badCount, samplesChecked, cyc, ckRise, rises;
	int                ph [LANES];
	integer            seed;

	ddr3_wl_if ddr3_wl_if_inst();
	ddr3_wl_ctrl ddr3_wl_ctrl_inst(.clock, .rst_n, .link(ddr3_wl_if_inst),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .initDone, .busy);
	ddr3_wl_device ddr3_wl_device_inst(.clock, .rst_n,
		.link(ddr3_wl_if_inst), .x16Mode, .levelingOn, .outputsOn,
		.dqsTermOn, .dqTermOn);
	ddr3_wl_checker ddr3_wl_checker_inst(.clock, .rst_n,
		.ck(ddr3_wl_if_inst.ck), .odt(ddr3_wl_if_inst.odt),
		.dqs(ddr3_wl_if_inst.dqs), .dqsOe(ddr3_wl_if_inst.dqsOe),
		.dqOutDev(ddr3_wl_if_inst.dqOutDev),
		.dqOeDev(ddr3_wl_if_inst.dqOeDev), .dq(ddr3_wl_if_inst.dq),
		.levelingOn, .outputsOn, .dqsTermOn, .dqTermOn, .x16Mode);

	// Clock at 200 MHz
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	// Strobe phase against the link clock; same-edge rises count as zero
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (ddr3_wl_if_inst.ck && !ckQ) ckRise = cyc;
		for (int i = 0; i < LANES; i++) begin
			if (ddr3_wl_if_inst.dqs[i] && !dqsQ[i]) begin
				ph[i] = cyc - ckRise;
				rises = rises + 1;
			end
		end
		if (levelingOn && !outputsOn) quietSeen = 1'b1;
		ckQ = ddr3_wl_if_inst.ck;
		dqsQ = ddr3_wl_if_inst.dqs;
	end

	task automatic report_and_stop();
		if (badCount == 0 && samplesChecked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] wd);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			badCount++;
			report_and_stop();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [31:0] status_exp(input logic [31:0] c);
		if (c[CTRL_QUIET]) return 32'h0000_0002;
		return c[CTRL_X16] ? 32'h0000_0032 : 32'h0000_0012;
	endfunction : status_exp

	// Start a sweep, poll for done, then check the link is back at rest
	task automatic run_level(input logic [31:0] c);
		int n;
		x16Mode <= c[CTRL_X16];
		rises = 0;
		quietSeen = 1'b0;
		apb(1'b1, REG_CTRL, c);
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (rd[ST_DONE] !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			badCount++;
			report_and_stop();
		end
		check(rd, status_exp(c));
		// A quiet run leaves its rank parked with outputs off
		check({26'h0, busy, dqsTermOn, outputsOn, levelingOn,
			ddr3_wl_if_inst.odt, ddr3_wl_if_inst.dqsOe[0]},
			{26'h0, 2'b00, !c[CTRL_QUIET], c[CTRL_QUIET],
			2'b00});
		apb(1'b0, REG_CTRL, 32'h0);
		check(rd, c & 32'h6);
		if (c[CTRL_QUIET]) begin
			check({31'h0, quietSeen}, 32'h1);
			check(rises, 0);
		end else begin
			apb(1'b0, REG_DELAY, 32'h0);
			// Strobe rises one cycle after its delay count
			tmp = {20'h0, 4'(c[CTRL_X16] ? ph[1] - 1 : 0), 4'h0,
				4'(ph[0] - 1)};
			check(rd & 32'h0F0F, tmp);
		end
	endtask : run_level

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 98646;
		{rst_n, psel, penable, pwrite, initDone, x16Mode} = '0;
		paddr = '0;
		pwdata = '0;
		{cyc, ckRise, rises, badCount, samplesChecked} = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0);
		check({31'h0, levelingOn}, 32'h0);
		// Unmapped place: refused with an error, reads zero
		tmp = $random(seed);
		apb(1'b0, {tmp[5:0] | 6'h03, 2'b00}, 32'h0);
		check({rd[30:0], err}, 32'h1);
		// Start is ignored until initialisation is reported done
		tmp = $random(seed);
		apb(1'b1, REG_CTRL, (tmp & 32'h6) | 32'h1);
		repeat (40) @(posedge clock);
		apb(1'b0, REG_STATUS, 32'h0);
		check(rd, 32'h0);
		initDone <= 1'b1;
		run_level(32'h3);
		run_level(32'h1);
		run_level(32'h5);
		run_level(32'h1);
		report_and_stop();
	end
endmodule : test_ddr3_write_leveling
